// ### hdl/cphz_pkg.sv
// shared constants for the core pipeline hazard block
package cphz_pkg;
	// pipeline depth, peripheral and stack delays in instruction cycles, counter limit, mode bit
	localparam int CPHZ_STAGES      = 7;
	localparam int CPHZ_STAT_DELAY  = 2;
	localparam int CPHZ_ROWIN_DELAY = 2;
	localparam int CPHZ_SSH_GAP     = 2;
	localparam int CPHZ_SC_MAX      = 15;
	localparam int CPHZ_MODE16_BIT  = 17;
	// register map, byte addresses
	localparam logic [7:0] CPHZ_OFF_CTRL   = 8'h00;
	localparam logic [7:0] CPHZ_OFF_STATUS = 8'h04;
	localparam logic [7:0] CPHZ_OFF_TXDATA = 8'h08;
	localparam logic [7:0] CPHZ_OFF_ROREG  = 8'h0C;
	localparam logic [7:0] CPHZ_OFF_HAZARD = 8'h10;
	localparam logic [7:0] CPHZ_OFF_SWORD  = 8'h14;
	// control bit positions
	localparam int CPHZ_CTRL_SXEN = 0;
	localparam int CPHZ_CTRL_DRAIN = 1;
	// hazard flag positions
	localparam int CPHZ_HZ_SSH_SEQ  = 0;
	localparam int CPHZ_HZ_SSH_BIT  = 1;
	localparam int CPHZ_HZ_XY_PRE   = 2;
	localparam int CPHZ_HZ_XY_POST  = 3;
	localparam int CPHZ_HZ_MODE16   = 4;
	localparam int CPHZ_HZ_ILLEGAL  = 5;
	localparam int CPHZ_HZ_W        = 6;
	// status layout
	localparam int CPHZ_ST_TXEMPTY  = 0;
	// instruction class codes on the issue port
	typedef enum logic [3:0] {
		CPHZ_OP_NOP, CPHZ_OP_SSH_READ, CPHZ_OP_SSH_WRITE, CPHZ_OP_SSH_BITMAN,
		CPHZ_OP_SSL_READ, CPHZ_OP_MOVE_NONY, CPHZ_OP_MOVE_XY, CPHZ_OP_MOVE_EP,
		CPHZ_OP_MOVE_SC, CPHZ_OP_RTI, CPHZ_OP_MOVE_DATA_ARITHMETIC_UNIT, CPHZ_OP_OTHER
	} cphz_op_t;
	localparam logic [31:0] CPHZ_RST_STATUS = 32'h0000_0001;
endpackage

// ### hdl/cphz_delay.sv
// short shift-register delay line used for pipeline staging
`timescale 1ns/100ps
`default_nettype none
module cphz_delay #(
	parameter int W     = 32,
	parameter int DEPTH = 2
) (
	input  wire logic         clk,   // core clock
	input  wire logic         rst,   // sync reset
	input  wire logic [W-1:0] din,   // stage input
	output logic      [W-1:0] dout   // value DEPTH cycles old
);
	logic [W-1:0] stage [DEPTH];

	// staging chain; read data come straight from the last flop
	genvar g;
	generate
		for (g = 0; g < DEPTH; g++) begin : g_st
			always_ff @(posedge clk) begin
				if (rst)
					stage[g] <= '0;
				else
					stage[g] <= (g == 0) ? din : stage[(g == 0) ? 0 : g-1];
			end
		end
	endgenerate
	assign dout = stage[DEPTH-1];
endmodule
`default_nettype wire

// ### hdl/cphz_core.sv
// pipeline hazard model of the core, with an AHB-Lite register slave
//
// Overview of operation
// - seven stages; hazards at listed cases, plus illegal EP or SC moves
// - peripheral status updates two cycles after write
// - read-only write ignored, but echoed two cycles
// - read then write of stack-high corrupts the next read
// - bit change on stack-high corrupts next read
// - dual move to I/O after dependent move fails
// - dual move feeding next non-Y move fails
// - mode bit change on return corrupts arithmetic move
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module cphz_core
	import cphz_pkg::*;
#(
	parameter int REGN = 5
) (
	input  wire logic          clk,          // core clock, 250 MHz
	input  wire logic          rst,          // sync reset, active high
	input  wire logic          hsel,         // slave select
	input  wire logic [31:0]   haddr,        // byte address
	input  wire logic [1:0]    htrans,       // transfer type
	input  wire logic          hwrite,       // write strobe
	input  wire logic [2:0]    hsize,        // word only
	input  wire logic          hready,       // bus ready
	input  wire logic [31:0]   hwdata,       // write data
	output logic [31:0]        hrdata,       // read data, registered
	output logic               hreadyout,    // always ready
	output logic               hresp,        // always OKAY
	input  wire logic          issue_valid,  // one instruction issued this cycle
	input  wire logic [3:0]    issue_op,     // instruction class
	input  wire logic [REGN-1:0] issue_src,  // source register id
	input  wire logic [REGN-1:0] issue_dst,  // destination register id
	input  wire logic          issue_xio,    // X destination is internal I/O
	input  wire logic [23:0]   issue_data,   // operand (counter value, status word)
	input  wire logic          tx_drained,   // peripheral shifted out its word
	output logic [CPHZ_HZ_W-1:0] hazard_now, // registered hazard of last issue
	output logic [CPHZ_STAGES-1:0] pipe_busy // stage occupancy
);
	// bus address phase capture
	logic        ap_wr;
	logic [7:0]  ap_addr;
	logic [31:0] ctrl;
	logic [31:0] txdata;
	logic [31:0] ro_value;
	logic [31:0] ro_shadow;
	logic [1:0]  ro_echo;
	logic        tx_empty;
	logic [CPHZ_HZ_W-1:0] hazard;
	logic [23:0] status_word;

	wire take     = hsel && hready && htrans[1];
	wire wr_data  = ap_wr;
	wire wr_ctrl  = wr_data && (ap_addr == CPHZ_OFF_CTRL);
	wire wr_tx    = wr_data && (ap_addr == CPHZ_OFF_TXDATA);
	wire wr_ro    = wr_data && (ap_addr == CPHZ_OFF_ROREG);
	wire wr_haz   = wr_data && (ap_addr == CPHZ_OFF_HAZARD);
	wire sx_en    = ctrl[CPHZ_CTRL_SXEN];

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// address phase registers
	always_ff @(posedge clk) begin
		if (rst) begin
			ap_wr   <= 1'b0;
			ap_addr <= 8'h00;
		end else begin
			ap_wr   <= take && hwrite;
			ap_addr <= haddr[7:0];
		end
	end

	// transmit path: empty flag lags the write by the pipeline delay
	logic [0:0] tx_wr_late;
	cphz_delay #(.W(1), .DEPTH(CPHZ_STAT_DELAY)) u_txdly (
		.clk  (clk),
		.rst  (rst),
		.din  (wr_tx),
		.dout (tx_wr_late)
	);
	always_ff @(posedge clk) begin
		if (rst)
			tx_empty <= CPHZ_RST_STATUS[CPHZ_ST_TXEMPTY];
		else if (tx_drained)
			tx_empty <= 1'b1; // drain wins: the shifter has taken the word
		else if (tx_wr_late[0])
			tx_empty <= 1'b0;
	end

	// software registers; read-only register keeps its contents
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl      <= 32'h0000_0000;
			txdata    <= 32'h0000_0000;
			ro_value  <= 32'h0000_0000;
			ro_shadow <= 32'h0000_0000;
			ro_echo   <= 2'h0;
		end else begin
			if (wr_ctrl)
				ctrl <= hwdata;
			if (wr_tx)
				txdata <= hwdata; // a write while not empty overwrites the pending word
			ro_value <= {8'h00, status_word};
			if (wr_ro) begin
				ro_shadow <= hwdata;
				ro_echo   <= 2'(CPHZ_ROWIN_DELAY);
			end else if (ro_echo != 2'h0)
				ro_echo <= ro_echo - 2'h1;
		end
	end

	// read mux, decoded in the address phase so data stand through the data phase
	wire [7:0]  rd_addr = haddr[7:0];
	wire [31:0] ro_read = (ro_echo != 2'h0) ? ro_shadow : ro_value;
	wire [31:0] rd_mux =
		(rd_addr == CPHZ_OFF_CTRL)   ? ctrl :
		(rd_addr == CPHZ_OFF_STATUS) ? {31'h0, tx_empty} :
		(rd_addr == CPHZ_OFF_TXDATA) ? txdata :
		(rd_addr == CPHZ_OFF_ROREG)  ? ro_read :
		(rd_addr == CPHZ_OFF_HAZARD) ? {26'h0, hazard} :
		(rd_addr == CPHZ_OFF_SWORD)  ? {8'h00, status_word} : 32'h0000_0000;

	// a read sees state as of its address phase; stale status follows from that
	always_ff @(posedge clk) begin
		if (rst)
			hrdata <= 32'h0000_0000;
		else if (take && !hwrite)
			hrdata <= rd_mux;
	end

	// pipeline occupancy: seven stages, forwarding hides normal dependencies
	always_ff @(posedge clk) begin
		if (rst)
			pipe_busy <= '0;
		else
			pipe_busy <= {pipe_busy[CPHZ_STAGES-2:0], issue_valid};
	end

	// previous two issued instructions, kept for the hazard checks
	cphz_op_t          op1;
	cphz_op_t          op2;
	logic [REGN-1:0]   dst1;
	logic [REGN-1:0]   src_next_y;
	logic              ssh_bit1;
	logic              mode_flip;
	logic              rti_pending;
	wire  cphz_op_t    op = cphz_op_t'(issue_op);

	function automatic logic is_ssh_read(input cphz_op_t o);
		return (o == CPHZ_OP_SSH_READ) || (o == CPHZ_OP_SSL_READ) ||
			(o == CPHZ_OP_SSH_BITMAN);
	endfunction

	wire seq_hz  = sx_en && (op2 == CPHZ_OP_SSH_READ) && (op1 == CPHZ_OP_SSH_WRITE)
		&& is_ssh_read(op);
	wire bit_hz  = sx_en && ssh_bit1 && is_ssh_read(op);
	wire xy_pre  = (op == CPHZ_OP_MOVE_XY) && issue_xio && (op1 == CPHZ_OP_MOVE_NONY)
		&& (issue_src == dst1);
	wire xy_post = (op == CPHZ_OP_MOVE_NONY) && (op1 == CPHZ_OP_MOVE_XY)
		&& (issue_src == src_next_y);
	wire m16_hz  = rti_pending && mode_flip && (op == CPHZ_OP_MOVE_DATA_ARITHMETIC_UNIT);
	wire ill_hz  = sx_en && ((op == CPHZ_OP_MOVE_EP) ||
		((op == CPHZ_OP_MOVE_SC) && (issue_data > 24'(CPHZ_SC_MAX))));

	// shift the history on every issued instruction
	always_ff @(posedge clk) begin
		if (rst) begin
			op1         <= CPHZ_OP_NOP;
			op2         <= CPHZ_OP_NOP;
			dst1        <= '0;
			src_next_y  <= '0;
			ssh_bit1    <= 1'b0;
			rti_pending <= 1'b0;
			mode_flip   <= 1'b0;
			status_word <= 24'h000000;
		end else if (issue_valid) begin
			op2         <= op1;
			op1         <= op;
			dst1        <= issue_dst;
			src_next_y  <= issue_dst;
			ssh_bit1    <= (op == CPHZ_OP_SSH_BITMAN);
			rti_pending <= (op == CPHZ_OP_RTI);
			if (op == CPHZ_OP_RTI) begin
				mode_flip   <= issue_data[CPHZ_MODE16_BIT] != status_word[CPHZ_MODE16_BIT];
				status_word <= issue_data;
			end
		end
	end

	// sticky hazard flags; a new hazard wins over a software clear
	wire [CPHZ_HZ_W-1:0] hz_set = issue_valid ?
		{ill_hz, m16_hz, xy_post, xy_pre, bit_hz, seq_hz} : '0;
	always_ff @(posedge clk) begin
		if (rst) begin
			hazard     <= '0;
			hazard_now <= '0;
		end else begin
			hazard     <= (wr_haz ? (hazard & ~hwdata[CPHZ_HZ_W-1:0]) : hazard) | hz_set;
			hazard_now <= hz_set;
		end
	end
endmodule
`default_nettype wire

// ### verif/cphz_properties.sv
// concurrent checks on the hazard flags and stage occupancy of the core
`timescale 1ns/100ps
`default_nettype none
module cphz_properties
	import cphz_pkg::*;
#(
	parameter int REGN = 5
) (
	input wire logic                   clk,         // core clock
	input wire logic                   rst,         // sync reset
	input wire logic                   issue_valid, // issue strobe
	input wire logic [3:0]             issue_op,    // class
	input wire logic [REGN-1:0]        issue_src,   // source id
	input wire logic [REGN-1:0]        issue_dst,   // destination id
	input wire logic                   issue_xio,   // x side is i/o
	input wire logic [CPHZ_HZ_W-1:0]   hazard_now,  // flags
	input wire logic [CPHZ_STAGES-1:0] pipe_busy    // stages
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// decoded moves and non-NOP issues, so each flag can be tied to the issue in the cycle before it
	wire logic v_nony = issue_valid && issue_op == CPHZ_OP_MOVE_NONY;
	wire logic v_xy   = issue_valid && issue_op == CPHZ_OP_MOVE_XY;
	wire logic v_real = issue_valid && issue_op != CPHZ_OP_NOP;
	chk_pipe_shift: assert property (!$past(rst) |->
		pipe_busy == {$past(pipe_busy[5:0]), $past(issue_valid)})
		else $error("stage occupancy is not a shift of issue");
	chk_xy_pre: assert property (v_xy && issue_xio && $past(v_nony) &&
		issue_src == $past(issue_dst) |=> hazard_now[CPHZ_HZ_XY_PRE])
		else $error("dependent move into i/o not flagged");
	chk_xy_post: assert property ($past(v_xy) && v_nony &&
		issue_src == $past(issue_dst) |=> hazard_now[CPHZ_HZ_XY_POST])
		else $error("move fed by dual move not flagged");
	chk_pre_cause: assert property (hazard_now[CPHZ_HZ_XY_PRE] |->
		$past(v_xy && issue_xio)) else $error("i/o move flag without cause");
	chk_post_cause: assert property (hazard_now[CPHZ_HZ_XY_POST] |->
		$past(v_nony)) else $error("feed flag without a following move");
	chk_seq_cause: assert property (hazard_now[CPHZ_HZ_SSH_SEQ] |->
		$past(v_real)) else $error("stack sequence flag without an issue");
	chk_bit_cause: assert property (hazard_now[CPHZ_HZ_SSH_BIT] |->
		$past(v_real)) else $error("bit change flag without an issue");
	chk_mode_cause: assert property (hazard_now[CPHZ_HZ_MODE16] |->
		$past(issue_valid && issue_op == CPHZ_OP_MOVE_DATA_ARITHMETIC_UNIT))
		else $error("mode flag without an arithmetic move");
	chk_illegal_cause: assert property (hazard_now[CPHZ_HZ_ILLEGAL] |->
		$past(issue_valid && issue_op inside {CPHZ_OP_MOVE_EP, CPHZ_OP_MOVE_SC}))
		else $error("illegal flag without a pointer or counter move");
endmodule
bind cphz_core cphz_properties #(.REGN(REGN)) u_cphz_properties (.clk(clk), .rst(rst),
	.issue_valid(issue_valid), .issue_op(issue_op), .issue_src(issue_src),
	.issue_dst(issue_dst), .issue_xio(issue_xio), .hazard_now(hazard_now),
	.pipe_busy(pipe_busy));
`default_nettype wire

// ### verif/cphz_periph.sv
// transmit peripheral that takes the pending word some cycles after a kick
`timescale 1ns/100ps
`default_nettype none
module cphz_periph #(
	parameter int LAT = 3
) (
	input wire logic clk,        // core clock
	input wire logic rst,        // sync reset
	input wire logic kick,       // start shifting out
	output logic     tx_drained  // word taken, one cycle
);
	int cnt;
	// the shifter is slow on purpose, so the empty flag must stay low meanwhile
	always_ff @(posedge clk) begin
		tx_drained <= !rst && cnt == 1;
		cnt <= rst ? 0 : kick ? LAT : (cnt > 0) ? cnt - 1 : 0;
	end
endmodule
`default_nettype wire

// ### verif/tb_core_pipeline_hazard_rules.sv
// self-checking bench for the pipeline hazard block
`timescale 1ns/100ps
`default_nettype none
`define CK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
	$display("unexpected at %0t: %h %h", $time, a, b); end end
module tb_core_pipeline_hazard_rules;
	import cphz_pkg::*;
	logic        clk = 0, rst = 1, hsel = 0, hwrite = 0, iv = 0, xio = 0, kick = 0;
	logic        hready, hresp, drained;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic [1:0]  htrans = 0;
	logic [3:0]  op = 0;
	logic [4:0]  src = 0, dst = 0;
	logic [23:0] idata = 0;
	logic [5:0]  hz;
	logic [6:0]  pb;
	int          errors = 0, checks_done = 0;
	cphz_core u_cphz_core (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hready(hready),
		.hwdata(hwdata), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
		.issue_valid(iv), .issue_op(op), .issue_src(src), .issue_dst(dst),
		.issue_xio(xio), .issue_data(idata), .tx_drained(drained), .hazard_now(hz),
		.pipe_busy(pb));
	cphz_periph u_cphz_periph (.clk(clk), .rst(rst), .kick(kick), .tx_drained(drained));
	always #2 clk = ~clk;
	// one single AHB transfer; read data is taken at the edge ending the data phase
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge clk); while (hready !== 1'b1);
		hsel <= 0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk); while (hready !== 1'b1);
		if (!w)
			rd = hrdata;
	endtask
	task automatic iss(input logic [3:0] o, input logic [4:0] s, t, input logic [23:0] d);
		@(posedge clk);
		iv <= 1;
		op <= o;
		src <= s;
		dst <= t;
		idata <= d;
	endtask
	// flags of the last issued instruction land one edge after its cycle
	task automatic hzc(input logic [5:0] e);
		@(posedge clk);
		iv <= 0;
		xio <= 0;
		#1 `CK(hz, e)
	endtask
	task automatic t_tx();
		bus(0, CPHZ_OFF_STATUS, 0);
		`CK(rd, CPHZ_RST_STATUS)
		bus(1, CPHZ_OFF_TXDATA, 32'h0000_00A5);
		bus(0, CPHZ_OFF_STATUS, 0);
		`CK(rd[0], 1'b1)
		bus(0, CPHZ_OFF_STATUS, 0);
		`CK(rd[0], 1'b0)
		kick <= 1;
		@(posedge clk);
		kick <= 0;
		repeat (6) @(posedge clk);
		bus(0, CPHZ_OFF_STATUS, 0);
		`CK(rd[0], 1'b1)
		bus(0, 8'h3C, 0);
		`CK(rd, 32'h0)
	endtask
	task automatic t_mode();
		iss(CPHZ_OP_RTI, 0, 0, 24'h00_0000);
		iss(CPHZ_OP_NOP, 0, 0, 0);
		iss(CPHZ_OP_RTI, 0, 0, 24'h02_0000);
		iss(CPHZ_OP_MOVE_DATA_ARITHMETIC_UNIT, 0, 0, 0);
		hzc(6'h10);
		// mode already restored before the return, so the move is clean
		iss(CPHZ_OP_NOP, 0, 0, 0);
		iss(CPHZ_OP_RTI, 0, 0, 24'h02_0000);
		iss(CPHZ_OP_MOVE_DATA_ARITHMETIC_UNIT, 0, 0, 0);
		hzc(6'h00);
		bus(0, CPHZ_OFF_SWORD, 0);
		`CK(rd, 32'h0002_0000)
		// a read-only write is echoed briefly, then the true word returns
		bus(1, CPHZ_OFF_ROREG, 32'h0000_5A5A);
		bus(0, CPHZ_OFF_ROREG, 0);
		`CK(rd, 32'h0000_5A5A)
		bus(0, CPHZ_OFF_ROREG, 0);
		`CK(rd, 32'h0002_0000)
	endtask
	task automatic t_stack();
		// no subroutine call ever sits at a stack error vector here
		bus(1, CPHZ_OFF_CTRL, 32'h1);
		iss(CPHZ_OP_SSH_READ, 0, 0, 0);
		iss(CPHZ_OP_SSH_WRITE, 0, 0, 0);
		iss(CPHZ_OP_SSL_READ, 0, 0, 0);
		hzc(6'h01);
		iss(CPHZ_OP_SSH_READ, 0, 0, 0);
		iss(CPHZ_OP_SSH_WRITE, 0, 0, 0);
		iss(CPHZ_OP_NOP, 0, 0, 0);
		iss(CPHZ_OP_NOP, 0, 0, 0);
		iss(CPHZ_OP_SSL_READ, 0, 0, 0);
		hzc(6'h00);
		iss(CPHZ_OP_SSH_BITMAN, 0, 0, 0);
		iss(CPHZ_OP_SSL_READ, 0, 0, 0);
		hzc(6'h02);
		iss(CPHZ_OP_SSH_BITMAN, 0, 0, 0);
		iss(CPHZ_OP_NOP, 0, 0, 0);
		iss(CPHZ_OP_NOP, 0, 0, 0);
		iss(CPHZ_OP_SSL_READ, 0, 0, 0);
		hzc(6'h00);
		iss(CPHZ_OP_MOVE_SC, 0, 0, 24'd16);
		hzc(6'h20);
		iss(CPHZ_OP_MOVE_SC, 0, 0, 24'd15);
		hzc(6'h00);
		iss(CPHZ_OP_MOVE_EP, 0, 0, 0);
		hzc(6'h20);
	endtask
	task automatic t_xy();
		iss(CPHZ_OP_MOVE_NONY, 0, 5'd3, 0);
		iss(CPHZ_OP_MOVE_XY, 5'd3, 5'd7, 0);
		xio <= 1;
		hzc(6'h04);
		iss(CPHZ_OP_MOVE_NONY, 0, 5'd3, 0);
		iss(CPHZ_OP_MOVE_XY, 5'd3, 5'd7, 0);
		hzc(6'h00);
		iss(CPHZ_OP_MOVE_XY, 5'd1, 5'd5, 0);
		iss(CPHZ_OP_MOVE_NONY, 5'd5, 5'd2, 0);
		hzc(6'h08);
		iss(CPHZ_OP_MOVE_NONY, 0, 5'd3, 0);
		iss(CPHZ_OP_NOP, 0, 0, 0);
		iss(CPHZ_OP_MOVE_XY, 5'd3, 5'd7, 0);
		xio <= 1;
		hzc(6'h00);
		// every flag seen so far is sticky until written with ones
		bus(0, CPHZ_OFF_HAZARD, 0);
		`CK(rd, 32'h0000_003F)
		bus(1, CPHZ_OFF_HAZARD, 32'h0000_003F);
		bus(0, CPHZ_OFF_HAZARD, 0);
		`CK(rd, 32'h0000_0000)
	endtask
	task automatic conclude();
		if (errors == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		`CK(hresp, 1'b0)
		t_tx();
		t_mode();
		t_stack();
		t_xy();
		conclude();
	end
	// a hang counts as a mismatch
	initial begin
		#20000;
		errors++;
		conclude();
	end
endmodule
`default_nettype wire
